// *** dv/icu_src.sv ***
/*
 * far-side source: drives the capture pin and the external timer clock.
 * assumes the bench calls edges() from its own sequence, after a clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module icu_src (
    input wire logic clk_in,
    output logic pin_out,
    output logic tclk_out
);
    initial begin
        pin_out = 1'b0;
        tclk_out = 1'b0;
    end
    // four cycles a level so the two-stage synchroniser sees every edge;
    // the timer clock stands low between bursts
    task automatic edges(input logic tclk, input int n);
        repeat (n) begin
            repeat (4) @(posedge clk_in);
            if (tclk) tclk_out <= 1'b1;
            else pin_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            if (tclk) tclk_out <= 1'b0;
            else pin_out <= 1'b0;
        end
        repeat (4) @(posedge clk_in);
    endtask
endmodule // icu_src
`default_nettype wire

// *** dv/tb.sv ***
/*
 * self-checking bench for icu_top: AXI4-Lite master, pin source, monitor.
 * assumes icu_pkg is compiled first and dv/icu_src.sv is present.
 */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0, rst_n = 1'b0, sleep = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    wire logic awready, wready, bvalid, arready, rvalid;
    wire logic pin_out, pin_oe, irq, src_pin, tclk, pin_lvl;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    int fail_count = 0, n_checks = 0, m;
    logic [33:0] expq[$];
    logic [15:0] v;
    // a driven pin reads back its own latch
    assign pin_lvl = pin_oe ? pin_out : src_pin;
    icu_top u_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .AWADDR_IN(awaddr),
        .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata),
        .WSTRB_IN(4'hF), .WVALID_IN(wvalid), .WREADY_OUT(wready),
        .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
        .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
        .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid),
        .RREADY_IN(rready), .CAP_PIN_IN(pin_lvl), .CAP_PIN_OUT(pin_out),
        .CAP_PIN_OE_OUT(pin_oe), .TMR_CLK_IN(tclk), .SLEEP_IN(sleep),
        .IRQ_OUT(irq));
    icu_src u_src (.clk_in(clk), .pin_out(src_pin), .tclk_out(tclk));
    initial begin
        forever #5 clk = ~clk;
    end
    function automatic logic [33:0] ok(input logic [31:0] d);
        ok = {icu_pkg::RESP_OKAY, d};
    endfunction
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = icu_pkg::RESP_OKAY);
        int k;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 50 && !bvalid; k++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (k == 50) begin
            fail_count++;
            results();
        end
        chk({32'h0, bresp}, {32'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int k;
        expq.push_back(e);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 50 && !rvalid; k++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (k == 50) begin
            fail_count++;
            results();
        end
    endtask
    // watcher: each accepted read answer meets the oldest expectation
    always @(posedge clk) begin
        if (rvalid && rready) begin
            if (expq.size() == 0) fail_count++;
            else chk({rresp, rdata}, expq.pop_front());
        end
    end
    task automatic set_mode(input logic [3:0] md);
        wr(icu_pkg::ADDR_CAP_CTRL, 32'(md));
        wr(icu_pkg::ADDR_FLAG, 32'h1);
    endtask
    task automatic rises(input int n, input logic f);
        u_src.edges(1'b0, n);
        rd(icu_pkg::ADDR_FLAG, ok({31'h0, f}));
    endtask
    initial begin
        void'($urandom(32'h0881_ea11));
        do_reset();
        rd(icu_pkg::ADDR_CAP_CTRL, ok(32'h0));
        rd(icu_pkg::ADDR_PIN, ok(32'h2));
        rd(8'h1C, {icu_pkg::RESP_SLVERR, 32'h0});
        wr(8'h1C, 32'h1, icu_pkg::RESP_SLVERR);
        for (m = 0; m < 2; m++) begin
            v = 16'($urandom);
            wr(icu_pkg::ADDR_TMR_CNT, {16'h0, v});
            wr(icu_pkg::ADDR_CAP_CTRL, m ? 32'h4 : 32'h5);
            u_src.edges(1'b0, 1);
            rd(icu_pkg::ADDR_CAP_RES, ok({16'h0, v}));
            rd(icu_pkg::ADDR_FLAG, ok(32'h1));
        end
        // interrupt follows flag and mask one edge later
        wr(icu_pkg::ADDR_MASK, 32'h1);
        @(posedge clk);
        chk({33'h0, irq}, 34'h1);
        wr(icu_pkg::ADDR_MASK, 32'h0);
        @(posedge clk);
        chk({33'h0, irq}, 34'h0);
        wr(icu_pkg::ADDR_FLAG, 32'h1);
        rd(icu_pkg::ADDR_FLAG, ok(32'h0));
        // off first, then every 4th and every 16th rise
        set_mode(icu_pkg::MODE_OFF);
        set_mode(icu_pkg::MODE_RISE4);
        rises(3, 1'b0);
        rises(1, 1'b1);
        set_mode(icu_pkg::MODE_OFF);
        set_mode(icu_pkg::MODE_RISE16);
        rises(15, 1'b0);
        rises(1, 1'b1);
        set_mode(icu_pkg::MODE_OFF);
        set_mode(icu_pkg::MODE_RISE16);
        rises(2, 1'b0);
        set_mode(icu_pkg::MODE_RISE4);
        rises(1, 1'b0);
        rises(1, 1'b1);
        for (m = 0; m < 2; m++) begin
            set_mode(icu_pkg::MODE_RISE4);
            rises(2, 1'b0);
            if (m) do_reset();
            else set_mode(icu_pkg::MODE_OFF);
            set_mode(icu_pkg::MODE_RISE4);
            rises(3, 1'b0);
            rises(1, 1'b1);
        end
        set_mode(icu_pkg::MODE_RISE);
        v = 16'($urandom);
        wr(icu_pkg::ADDR_TMR_CNT, {16'h0, v});
        wr(icu_pkg::ADDR_PIN, 32'h0);
        wr(icu_pkg::ADDR_PIN, 32'h1);
        chk({33'h0, pin_oe}, 34'h1);
        chk({33'h0, pin_out}, 34'h1);
        repeat (6) @(posedge clk);
        rd(icu_pkg::ADDR_CAP_RES, ok({16'h0, v}));
        wr(icu_pkg::ADDR_PIN, 32'h2);
        sleep <= 1'b1;
        wr(icu_pkg::ADDR_TMR_CTRL, 32'h1);
        wr(icu_pkg::ADDR_TMR_CNT, {16'h0, v});
        repeat (20) @(posedge clk);
        rd(icu_pkg::ADDR_TMR_CNT, ok({16'h0, v}));
        wr(icu_pkg::ADDR_TMR_CTRL, 32'h5);
        u_src.edges(1'b1, 5);
        rd(icu_pkg::ADDR_TMR_CNT, ok({16'h0, v + 16'h5}));
        wr(icu_pkg::ADDR_TMR_CTRL, 32'hD);
        u_src.edges(1'b1, 3);
        rd(icu_pkg::ADDR_TMR_CNT, ok({16'h0, v + 16'h8}));
        set_mode(icu_pkg::MODE_RISE);
        rises(1, 1'b1);
        rd(icu_pkg::ADDR_CAP_RES, ok({16'h0, v + 16'h8}));
        results();
    end
endmodule // tb
`default_nettype wire

// *** include/icu_pkg.sv ***
/*
 * Constants, register map and mode decoding for the input capture unit.
 * Assumes a single 100 MHz system clock and a 32-bit AXI4-Lite master.
 */
// Notes on behaviour
// - capture copies full 16-bit timer count
// - four events: fall, rise, 4th, 16th rise
// - capture sets flag, only software clears it
// - newer capture overwrites unread result
// - driven pin latch writes can capture
// - prescaler held zero when off or not capture
// - every reset clears the prescaler
// - prescaler switch keeps count, may capture
// - instruction clock timer freezes during sleep
// - external clock captures continue in sleep
// - external timer clock always synchronized, depth selectable
`default_nettype none
package icu_pkg;
    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] ADDR_CAP_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TMR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_TMR_CNT = 8'h08;
    localparam logic [7:0] ADDR_CAP_RES = 8'h0C;
    localparam logic [7:0] ADDR_FLAG = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;
    localparam logic [7:0] ADDR_PIN = 8'h18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned TMR_ON_BIT = 0;
    localparam int unsigned TMR_SRC_LSB = 1;
    localparam int unsigned TMR_NOSYNC_BIT = 3;
    localparam int unsigned PIN_LATCH_BIT = 0;
    localparam int unsigned PIN_DIR_BIT = 1;
    localparam int unsigned FLAG_BIT = 0;
    localparam logic [3:0] MODE_RST = 4'h0;
    localparam logic [15:0] CNT_RST = 16'h0000;
    // ------------------------------------------------------------------
    // event select encoding
    // ------------------------------------------------------------------
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_FALL = 4'h4;
    localparam logic [3:0] MODE_RISE = 4'h5;
    localparam logic [3:0] MODE_RISE4 = 4'h6;
    localparam logic [3:0] MODE_RISE16 = 4'h7;
    localparam logic [3:0] PRESC_RST = 4'h0;
    localparam logic [1:0] PRESC4_LAST = 2'h3;
    localparam logic [3:0] PRESC16_LAST = 4'hF;
    // ------------------------------------------------------------------
    // reference timer clock sources and timing
    // ------------------------------------------------------------------
    localparam logic [1:0] SRC_INSTR = 2'h0;
    localparam logic [1:0] SRC_SYS = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned INSTR_DIV = 4;
    localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

    function automatic logic is_capture(input logic [3:0] mode);
        is_capture = (mode == MODE_FALL) || (mode == MODE_RISE) ||
                     (mode == MODE_RISE4) || (mode == MODE_RISE16);
    endfunction

    function automatic logic reg_mapped(input logic [7:0] addr);
        reg_mapped = (addr == ADDR_CAP_CTRL) || (addr == ADDR_TMR_CTRL) ||
                     (addr == ADDR_TMR_CNT) || (addr == ADDR_CAP_RES) ||
                     (addr == ADDR_FLAG) || (addr == ADDR_MASK) ||
                     (addr == ADDR_PIN);
    endfunction
endpackage
`default_nettype wire

// *** src/icu_timer.sv ***
/*
 * 16-bit reference timer: instruction clock, system clock or external pin.
 * Assumes the external clock pin is asynchronous and slower than clk/4.
 */
`timescale 1ns/10ps
`default_nettype none
module icu_timer (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic on_in,
    input wire logic [1:0] src_in,
    input wire logic nosync_in,
    input wire logic sleep_in,
    input wire logic ext_clk_in,
    input wire logic load_in,
    input wire logic [15:0] load_val_in,
    output logic [15:0] count_out
);
    logic [1:0] div_r;
    logic ext_s1_r, ext_s2_r, ext_s3_r, ext_s4_r;
    logic [15:0] count_r;
    wire logic instr_tick;
    wire logic ext_tick;
    wire logic tick;

    // ------------------------------------------------------------------
    // tick selection
    // ------------------------------------------------------------------
    assign instr_tick = (div_r == icu_pkg::INSTR_LAST);
    assign ext_tick = nosync_in ? (ext_s2_r & ~ext_s3_r)
                                : (ext_s3_r & ~ext_s4_r);
    assign tick = on_in & ((src_in == icu_pkg::SRC_INSTR) ?
                           (instr_tick & ~sleep_in) :
                           (src_in == icu_pkg::SRC_SYS) ? ~sleep_in :
                           ext_tick);
    assign count_out = count_r;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_r <= 2'h0;
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
            ext_s4_r <= 1'b0;
        end else begin
            div_r <= div_r + 2'h1;
            ext_s1_r <= ext_clk_in;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            ext_s4_r <= ext_s3_r;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_r <= icu_pkg::CNT_RST;
        end else if (load_in) begin
            count_r <= load_val_in;
        end else if (tick) begin
            count_r <= count_r + 16'h0001;
        end
    end

    a_sleep_freeze: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        sleep_in && !load_in && src_in == icu_pkg::SRC_INSTR
        |=> count_r == $past(count_r))
        else $error("timer moved during sleep");
endmodule // icu_timer
`default_nettype wire

// *** src/icu_top.sv ***
/*
 * Input capture unit with AXI4-Lite registers and one level interrupt.
 * Assumes CAP_PIN_IN and TMR_CLK_IN are asynchronous pins; SLEEP_IN and
 * the bus are on CLK_IN.
 */
`timescale 1ns/10ps
`default_nettype none
module icu_top (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [7:0] AWADDR_IN,
    input wire logic AWVALID_IN,
    output logic AWREADY_OUT,
    input wire logic [31:0] WDATA_IN,
    input wire logic [3:0] WSTRB_IN,
    input wire logic WVALID_IN,
    output logic WREADY_OUT,
    output logic [1:0] BRESP_OUT,
    output logic BVALID_OUT,
    input wire logic BREADY_IN,
    input wire logic [7:0] ARADDR_IN,
    input wire logic ARVALID_IN,
    output logic ARREADY_OUT,
    output logic [31:0] RDATA_OUT,
    output logic [1:0] RRESP_OUT,
    output logic RVALID_OUT,
    input wire logic RREADY_IN,
    input wire logic CAP_PIN_IN,
    output logic CAP_PIN_OUT,
    output logic CAP_PIN_OE_OUT,
    input wire logic TMR_CLK_IN,
    input wire logic SLEEP_IN,
    output logic IRQ_OUT
);
    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic aw_got_r, w_got_r, awready_r, wready_r, bvalid_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic [1:0] bresp_r, rresp_r;
    logic arready_r, rvalid_r;
    logic [31:0] rdata_r;
    logic [3:0] mode_r, presc_r;
    logic tmr_on_r, tmr_nosync_r;
    logic [1:0] tmr_src_r;
    logic pin_latch_r, pin_oe_r;
    logic cap_s1_r, cap_s2_r, cap_prev_r;
    logic [15:0] result_r;
    logic flag_r, mask_r, irq_r;
    logic [3:0] presc_nxt;
    logic flag_nxt, aw_got_nxt, w_got_nxt, rvalid_nxt;
    wire logic [15:0] tmr_count;
    wire logic aw_hs, w_hs, ar_hs, wr_go, wr_b0, wr_b1;
    wire logic wr_cap_ctrl, wr_tmr_ctrl, wr_tmr_cnt;
    wire logic wr_flag, wr_mask, wr_pin, flag_clr;
    wire logic [15:0] tmr_load_val;
    wire logic [31:0] rd_mux;
    wire logic cap_src, cap_rise, cap_fall, cap_mode, cap_event;
    default clocking cb_chk @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    // ------------------------------------------------------------------
    // reference timer
    // ------------------------------------------------------------------
    icu_timer u_timer (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .on_in(tmr_on_r),
        .src_in(tmr_src_r),
        .nosync_in(tmr_nosync_r),
        .sleep_in(SLEEP_IN),
        .ext_clk_in(TMR_CLK_IN),
        .load_in(wr_tmr_cnt),
        .load_val_in(tmr_load_val),
        .count_out(tmr_count)
    );

    // ------------------------------------------------------------------
    // write channel: address and data in either order
    // ------------------------------------------------------------------
    assign aw_hs = AWVALID_IN & awready_r;
    assign w_hs = WVALID_IN & wready_r;
    assign wr_go = aw_got_r & w_got_r & ~bvalid_r;
    assign wr_b0 = wr_go & w_strb_r[0];
    assign wr_b1 = wr_go & w_strb_r[1];
    assign wr_cap_ctrl = wr_b0 & (aw_addr_r == icu_pkg::ADDR_CAP_CTRL);
    assign wr_tmr_ctrl = wr_b0 & (aw_addr_r == icu_pkg::ADDR_TMR_CTRL);
    assign wr_tmr_cnt = (wr_b0 | wr_b1) &
                        (aw_addr_r == icu_pkg::ADDR_TMR_CNT);
    assign wr_flag = wr_b0 & (aw_addr_r == icu_pkg::ADDR_FLAG);
    assign wr_mask = wr_b0 & (aw_addr_r == icu_pkg::ADDR_MASK);
    assign wr_pin = wr_b0 & (aw_addr_r == icu_pkg::ADDR_PIN);
    assign flag_clr = wr_flag & w_data_r[icu_pkg::FLAG_BIT];
    assign tmr_load_val = {w_strb_r[1] ? w_data_r[15:8] : tmr_count[15:8],
                           w_strb_r[0] ? w_data_r[7:0] : tmr_count[7:0]};

    always_comb begin
        aw_got_nxt = wr_go ? 1'b0 : (aw_got_r | aw_hs);
        w_got_nxt = wr_go ? 1'b0 : (w_got_r | w_hs);
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
        end else begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awready_r <= ~aw_got_nxt;
            wready_r <= ~w_got_nxt;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_addr_r <= AWADDR_IN;
            end
            if (w_hs) begin
                w_data_r <= WDATA_IN;
                w_strb_r <= WSTRB_IN;
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            bvalid_r <= 1'b0;
            bresp_r <= icu_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= icu_pkg::reg_mapped(aw_addr_r) ?
                       icu_pkg::RESP_OKAY : icu_pkg::RESP_SLVERR;
        end else if (BREADY_IN) begin
            bvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // read channel: answer one cycle after the address is taken
    // ------------------------------------------------------------------
    assign ar_hs = ARVALID_IN & arready_r;
    assign rd_mux =
        (ARADDR_IN == icu_pkg::ADDR_CAP_CTRL) ? {28'h000_0000, mode_r} :
        (ARADDR_IN == icu_pkg::ADDR_TMR_CTRL) ?
            {28'h000_0000, tmr_nosync_r, tmr_src_r, tmr_on_r} :
        (ARADDR_IN == icu_pkg::ADDR_TMR_CNT) ? {16'h0000, tmr_count} :
        (ARADDR_IN == icu_pkg::ADDR_CAP_RES) ? {16'h0000, result_r} :
        (ARADDR_IN == icu_pkg::ADDR_FLAG) ? {31'h0000_0000, flag_r} :
        (ARADDR_IN == icu_pkg::ADDR_MASK) ? {31'h0000_0000, mask_r} :
        (ARADDR_IN == icu_pkg::ADDR_PIN) ?
            {30'h0000_0000, ~pin_oe_r, pin_latch_r} : 32'h0000_0000;

    always_comb begin
        rvalid_nxt = ar_hs | (rvalid_r & ~RREADY_IN);
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= icu_pkg::RESP_OKAY;
        end else begin
            rvalid_r <= rvalid_nxt;
            arready_r <= ~rvalid_nxt;
            if (ar_hs) begin
                rdata_r <= rd_mux;
                rresp_r <= icu_pkg::reg_mapped(ARADDR_IN) ?
                           icu_pkg::RESP_OKAY : icu_pkg::RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            mode_r <= icu_pkg::MODE_RST;
            tmr_on_r <= 1'b0;
            tmr_src_r <= icu_pkg::SRC_INSTR;
            tmr_nosync_r <= 1'b0;
            mask_r <= 1'b0;
            pin_latch_r <= 1'b0;
            pin_oe_r <= 1'b0;
        end else begin
            if (wr_cap_ctrl) begin
                mode_r <= w_data_r[3:0];
            end
            if (wr_tmr_ctrl) begin
                tmr_on_r <= w_data_r[icu_pkg::TMR_ON_BIT];
                tmr_src_r <= w_data_r[icu_pkg::TMR_SRC_LSB +: 2];
                tmr_nosync_r <= w_data_r[icu_pkg::TMR_NOSYNC_BIT];
            end
            if (wr_mask) begin
                mask_r <= w_data_r[icu_pkg::FLAG_BIT];
            end
            if (wr_pin) begin
                pin_latch_r <= w_data_r[icu_pkg::PIN_LATCH_BIT];
                // direction bit high means input, so the driver is off
                pin_oe_r <= ~w_data_r[icu_pkg::PIN_DIR_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // capture pin and event detection
    // ------------------------------------------------------------------
    // driven pin reads back its latch
    assign cap_src = pin_oe_r ? pin_latch_r : cap_s2_r;
    assign cap_rise = cap_src & ~cap_prev_r;
    assign cap_fall = ~cap_src & cap_prev_r;
    // decode of the event select field
    assign cap_mode = icu_pkg::is_capture(mode_r);
    assign cap_event =
        ((mode_r == icu_pkg::MODE_FALL) & cap_fall) |
        ((mode_r == icu_pkg::MODE_RISE) & cap_rise) |
        ((mode_r == icu_pkg::MODE_RISE4) & cap_rise &
         (presc_r[1:0] == icu_pkg::PRESC4_LAST)) |
        ((mode_r == icu_pkg::MODE_RISE16) & cap_rise &
         (presc_r == icu_pkg::PRESC16_LAST));

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            cap_s1_r <= 1'b0;
            cap_s2_r <= 1'b0;
            cap_prev_r <= 1'b0;
        end else begin
            cap_s1_r <= CAP_PIN_IN;
            cap_s2_r <= cap_s1_r;
            cap_prev_r <= cap_src;
        end
    end

    always_comb begin
        presc_nxt = presc_r;
        if (!cap_mode) begin
            presc_nxt = icu_pkg::PRESC_RST;
        end else if (cap_rise && (mode_r == icu_pkg::MODE_RISE4 ||
                                  mode_r == icu_pkg::MODE_RISE16)) begin
            presc_nxt = presc_r + 4'h1;
        end
    end

    always_comb begin
        flag_nxt = cap_event | (flag_r & ~flag_clr);
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            presc_r <= icu_pkg::PRESC_RST;
            flag_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            presc_r <= presc_nxt;
            flag_r <= flag_nxt;
            irq_r <= flag_r & mask_r;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            result_r <= icu_pkg::CNT_RST;
        end else if (cap_event) begin
            result_r <= tmr_count;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign AWREADY_OUT = awready_r;
    assign WREADY_OUT = wready_r;
    assign BVALID_OUT = bvalid_r;
    assign BRESP_OUT = bresp_r;
    assign ARREADY_OUT = arready_r;
    assign RVALID_OUT = rvalid_r;
    assign RDATA_OUT = rdata_r;
    assign RRESP_OUT = rresp_r;
    assign CAP_PIN_OUT = pin_latch_r;
    assign CAP_PIN_OE_OUT = pin_oe_r;
    assign IRQ_OUT = irq_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_result_copy: assert property (
        cap_event |=> result_r == $past(tmr_count))
        else $error("capture did not copy the timer");
    a_fall_event: assert property (
        mode_r == icu_pkg::MODE_FALL && cap_fall |-> cap_event)
        else $error("falling edge not captured");
    a_fourth_rise: assert property (
        cap_event && mode_r == icu_pkg::MODE_RISE4
        |-> cap_rise && presc_r[1:0] == icu_pkg::PRESC4_LAST)
        else $error("every-fourth capture on wrong edge");
    a_flag_sticky: assert property (
        (cap_event || (flag_r && !flag_clr)) |=> flag_r)
        else $error("capture flag lost");
    // an unserviced earlier capture must not protect its value
    a_overwrite: assert property (
        cap_event && flag_r |=> result_r == $past(tmr_count))
        else $error("second capture did not overwrite");
    a_port_edge: assert property (
        mode_r == icu_pkg::MODE_RISE && pin_oe_r && $past(pin_oe_r) &&
        $rose(pin_latch_r) |-> cap_event)
        else $error("latch write edge not captured");
    a_presc_off: assert property (
        !cap_mode |=> presc_r == icu_pkg::PRESC_RST)
        else $error("prescaler not held at zero");
    a_presc_keep: assert property (
        cap_mode && !cap_rise |=> presc_r == $past(presc_r))
        else $error("prescaler changed without an edge");
    a_pin_sync: assert property (
        $rose(cap_s2_r) |-> $past(CAP_PIN_IN, 2))
        else $error("pin not delayed by two stages");
    a_irq_level: assert property (
        flag_r && mask_r |=> IRQ_OUT)
        else $error("interrupt not raised");
endmodule // icu_top
`default_nettype wire
